// *** inc/dfpm_pkg.sv ***
// Package of constants shared by the dual function pin mux design.
package dfpm_pkg;

  // Register indices on the plain register port.
  localparam logic [3:0] ADDR_FLAG_OUT = 4'h0;
  localparam logic [3:0] ADDR_FLAG_DIR = 4'h1;
  localparam logic [3:0] ADDR_FLAG_IN = 4'h2;
  localparam logic [3:0] ADDR_SYS_CTRL = 4'h3;
  localparam logic [3:0] ADDR_INT_MASK = 4'h4;
  localparam logic [3:0] ADDR_INT_STATUS = 4'h5;
  localparam logic [3:0] ADDR_SENSE_CFG = 4'h6;
  localparam logic [3:0] ADDR_STRAPS = 4'h7;

  localparam int FLAG_COUNT = 8;
  localparam int STRAP_COUNT = 4;
  localparam int INT_COUNT = 4;

  // Interrupt status bit positions.
  localparam int INT_BIT_SELECTABLE = 0;
  localparam int INT_BIT_LEVEL_B = 1;
  localparam int INT_BIT_LEVEL_A = 2;
  localparam int INT_BIT_EDGE_ONLY = 3;

  // Flag pin numbers that carry the interrupt functions.
  localparam int FLAG_OF_SELECTABLE = 7;
  localparam int FLAG_OF_LEVEL_B = 6;
  localparam int FLAG_OF_LEVEL_A = 5;
  localparam int FLAG_OF_EDGE_ONLY = 4;

  // Strap positions; strap n shares flag pin n.
  localparam int STRAP_MEM_MODE = 2;

  // System control field: serial port pin function select.
  localparam int SCTRL_SERIAL_SEL_BIT = 0;
  localparam logic [15:0] SYS_CTRL_RESET = 16'h0000;
  localparam logic [15:0] FLAG_DIR_RESET = 16'h0000;

  typedef enum logic [1:0] {
    DFPM_MODE_FULL_MEMORY = 2'b01,
    DFPM_MODE_HOST = 2'b10
  } dfpm_mem_mode_type;

endpackage

// *** hw/dfpm_int_detect.sv ***
// Interrupt sense logic for one pin: edge or level detection.
`timescale 1ns/1ns
module dfpm_int_detect
  import dfpm_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  input wire logic edge_mode_i,
  output logic event_o
);

  logic pin_prev_reg;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    // Starts at the idle high level of the pin, so a pin already low at release reads as a falling edge.
    if (!rst_n_i)
      pin_prev_reg <= 1'b1;
    else
      pin_prev_reg <= pin_i;
  end

  // Requests are active low on the pin; a level request repeats while held.
  always_comb
  begin
    if (edge_mode_i)
      event_o = pin_prev_reg && !pin_i;
    else
      event_o = !pin_i;
  end

endmodule // dfpm_int_detect

// *** hw/dfpm_pin_mux.sv ***
// Top of the dual function pin mux: straps, flags, shared interrupts, serial pin select.
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
module dfpm_pin_mux
  import dfpm_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [15:0] reg_rdata_o,
  input wire logic [FLAG_COUNT-1:0] flag_pin_i,
  output logic [FLAG_COUNT-1:0] flag_pin_o,
  output logic [FLAG_COUNT-1:0] flag_pin_oe_o,
  output logic serial_shared_sel_o,
  output logic host_mode_o,
  output logic [STRAP_COUNT-1:0] strap_value_o,
  output logic [INT_COUNT-1:0] int_vector_req_o,
  output logic irq_o
);

  logic rst_sync1_reg;
  logic rst_sync2_reg;
  logic rst_n;
  logic strap_done_reg;
  logic [STRAP_COUNT-1:0] strap_reg;
  dfpm_mem_mode_type mem_mode_reg;
  logic [FLAG_COUNT-1:0] flag_out_reg;
  logic [FLAG_COUNT-1:0] flag_dir_reg;
  logic [15:0] sys_ctrl_reg;
  logic [INT_COUNT-1:0] interrupt_mask_reg;
  logic [INT_COUNT-1:0] int_status_reg;
  logic [INT_COUNT-1:0] int_status_next;
  logic selectable_edge_reg;
  logic [INT_COUNT-1:0] int_event;
  logic [INT_COUNT-1:0] int_pin;
  logic [FLAG_COUNT-1:0] pin_level;
  logic [15:0] rdata_next;
  // Write strobe per writable register.
  logic flag_out_we;
  logic flag_dir_we;
  logic sys_ctrl_we;
  logic int_mask_we;
  logic int_status_we;
  logic sense_cfg_we;

  // Bit of the sense register that puts the selectable interrupt into edge mode.
  localparam int SENSE_EDGE_BIT = 0;

  // The fixed pin map needs every interrupt on a flag pin that is not also a strap.
  generate
    if (STRAP_COUNT > FLAG_COUNT ||
        STRAP_MEM_MODE >= STRAP_COUNT ||
        FLAG_COUNT > $bits(reg_rdata_o) ||
        INT_BIT_EDGE_ONLY >= INT_COUNT ||
        FLAG_OF_SELECTABLE >= FLAG_COUNT ||
        FLAG_OF_LEVEL_B >= FLAG_COUNT ||
        FLAG_OF_LEVEL_A >= FLAG_COUNT ||
        FLAG_OF_EDGE_ONLY < STRAP_COUNT)
    begin : g_config_check
      $error("Pin mux constants do not fit the fixed pin map.");
    end
  endgenerate

  // Reset release through two flip-flops.
  // Assertion stays asynchronous; only the release is lined up with the clock.
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end
    else
    begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end

  // Everything below resets from this released copy, never from the pin itself.
  assign rst_n = rst_sync2_reg;

  // Write strobes decoded once so every register block tests the same condition.
  assign flag_out_we = reg_write_i && (reg_addr_i == ADDR_FLAG_OUT);
  assign flag_dir_we = reg_write_i && (reg_addr_i == ADDR_FLAG_DIR);
  assign sys_ctrl_we = reg_write_i && (reg_addr_i == ADDR_SYS_CTRL);
  assign int_mask_we = reg_write_i && (reg_addr_i == ADDR_INT_MASK);
  assign int_status_we = reg_write_i && (reg_addr_i == ADDR_INT_STATUS);
  assign sense_cfg_we = reg_write_i && (reg_addr_i == ADDR_SENSE_CFG);

  // The pins are sampled by a clocked process on the first edge after release, never
  // by the asynchronous reset itself; the flags are still undriven at that edge.
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_done_reg <= 1'b0;
      strap_reg <= '0;
      mem_mode_reg <= DFPM_MODE_FULL_MEMORY;
    end
    else if (!strap_done_reg)
    begin
      strap_done_reg <= 1'b1;
      strap_reg <= flag_pin_i[STRAP_COUNT-1:0];
      if (flag_pin_i[STRAP_MEM_MODE])
        mem_mode_reg <= DFPM_MODE_HOST;
      else
        mem_mode_reg <= DFPM_MODE_FULL_MEMORY;
    end
  end

  // Flag data register; bits 3..0 serve as flags once straps are taken.
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      flag_out_reg <= '0;
    else if (flag_out_we)
      flag_out_reg <= reg_wdata_i[FLAG_COUNT-1:0];
  end

  // Flag direction register; a one makes the pin an output.
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      flag_dir_reg <= FLAG_DIR_RESET[FLAG_COUNT-1:0];
    else if (flag_dir_we)
      flag_dir_reg <= reg_wdata_i[FLAG_COUNT-1:0];
  end

  // Pin drivers stay off until the straps have been taken, so a strap is never overdriven.
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_pin_o <= '0;
      flag_pin_oe_o <= '0;
    end
    else
    begin
      flag_pin_o <= flag_out_reg;
      flag_pin_oe_o <= strap_done_reg ? flag_dir_reg : '0;
    end
  end

  // The pin level seen by the interrupt logic is the driven value when driving,
  // so a flag written by software raises its own interrupt.
  assign pin_level = (flag_pin_oe_o & flag_pin_o) | (~flag_pin_oe_o & flag_pin_i);

  // System control and serial pin select, writable at any time.
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      sys_ctrl_reg <= SYS_CTRL_RESET;
    else if (sys_ctrl_we)
      sys_ctrl_reg <= reg_wdata_i;
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      serial_shared_sel_o <= 1'b0;
    else
      serial_shared_sel_o <= sys_ctrl_reg[SCTRL_SERIAL_SEL_BIT];
  end

  // Mode and strap outputs show only the captured copy, so later pin activity cannot move them.
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      host_mode_o <= 1'b0;
      strap_value_o <= '0;
    end
    else
    begin
      host_mode_o <= (mem_mode_reg == DFPM_MODE_HOST);
      strap_value_o <= strap_reg;
    end
  end

  // Interrupt mask, one bit per shared interrupt.
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      interrupt_mask_reg <= '0;
    else if (int_mask_we)
      interrupt_mask_reg <= reg_wdata_i[INT_COUNT-1:0];
  end

  // Sense select for the one interrupt that may be edge or level triggered.
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      selectable_edge_reg <= 1'b0;
    else if (sense_cfg_we)
      selectable_edge_reg <= reg_wdata_i[SENSE_EDGE_BIT];
  end

  // Each interrupt watches the level of the flag pin it shares.
  assign int_pin[INT_BIT_SELECTABLE] = pin_level[FLAG_OF_SELECTABLE];
  assign int_pin[INT_BIT_LEVEL_B] = pin_level[FLAG_OF_LEVEL_B];
  assign int_pin[INT_BIT_LEVEL_A] = pin_level[FLAG_OF_LEVEL_A];
  assign int_pin[INT_BIT_EDGE_ONLY] = pin_level[FLAG_OF_EDGE_ONLY];

  // One detector per shared interrupt; only the selectable one has a programmable sense.
  genvar gi;
  generate
    for (gi = 0; gi < INT_COUNT; gi++)
    begin : g_int
      logic edge_mode;
      if (gi == INT_BIT_SELECTABLE)
        assign edge_mode = selectable_edge_reg;
      else if (gi == INT_BIT_EDGE_ONLY)
        assign edge_mode = 1'b1;
      else
        assign edge_mode = 1'b0;
      dfpm_int_detect u_detect (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n),
        .pin_i(int_pin[gi]),
        .edge_mode_i(edge_mode),
        .event_o(int_event[gi])
      );
    end
  endgenerate

  // Sticky status: write one to clear, a new event in the same cycle wins.
  always_comb
  begin
    int_status_next = int_status_reg;
    if (int_status_we)
      int_status_next = int_status_reg & ~reg_wdata_i[INT_COUNT-1:0];
    if (strap_done_reg)
      int_status_next = int_status_next | int_event;
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      int_status_reg <= '0;
    else
      int_status_reg <= int_status_next;
  end

  // Vector requests and the summary interrupt follow status and mask.
  // Built from the next status value so a request appears on the edge that sets its bit.
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_vector_req_o <= '0;
      irq_o <= 1'b0;
    end
    else
    begin
      int_vector_req_o <= int_status_next & interrupt_mask_reg;
      irq_o <= |(int_status_next & interrupt_mask_reg);
    end
  end

  // Register read port; unmapped addresses read zero.
  // Read data stand for the one cycle after the strobe and are zero otherwise.
  always_comb
  begin
    rdata_next = 16'h0000;
    case (reg_addr_i)
      ADDR_FLAG_OUT: rdata_next[FLAG_COUNT-1:0] = flag_out_reg;
      ADDR_FLAG_DIR: rdata_next[FLAG_COUNT-1:0] = flag_dir_reg;
      ADDR_FLAG_IN: rdata_next[FLAG_COUNT-1:0] = pin_level;
      ADDR_SYS_CTRL: rdata_next = sys_ctrl_reg;
      ADDR_INT_MASK: rdata_next[INT_COUNT-1:0] = interrupt_mask_reg;
      ADDR_INT_STATUS: rdata_next[INT_COUNT-1:0] = int_status_reg;
      ADDR_SENSE_CFG: rdata_next[SENSE_EDGE_BIT] = selectable_edge_reg;
      ADDR_STRAPS: rdata_next[STRAP_COUNT-1:0] = strap_reg;
      default: rdata_next = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_o <= 16'h0000;
    else if (reg_read_i)
      reg_rdata_o <= rdata_next;
    else
      reg_rdata_o <= 16'h0000;
  end

endmodule // dfpm_pin_mux

// *** verif/dfpm_pin_mux_properties.sv ***
// Port-level checks for the dual function pin mux.
`timescale 1ns/1ns
module dfpm_pin_mux_properties
  import dfpm_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic [FLAG_COUNT-1:0] flag_pin_o,
  input wire logic [FLAG_COUNT-1:0] flag_pin_oe_o,
  input wire logic serial_shared_sel_o,
  input wire logic host_mode_o,
  input wire logic [STRAP_COUNT-1:0] strap_value_o,
  input wire logic [INT_COUNT-1:0] int_vector_req_o,
  input wire logic irq_o
);
  logic [3:0] release_count_reg;
  // Cycles since the reset pin was released, held at its top value.
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      release_count_reg <= 4'h0;
    else if (release_count_reg != 4'hf)
      release_count_reg <= release_count_reg + 4'h1;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  strap_fixed_a: assert property ($changed(strap_value_o) |-> release_count_reg == 4'h4)
    else $error("strap value changed after capture");
  host_strap_a: assert property (host_mode_o == strap_value_o[STRAP_MEM_MODE])
    else $error("host mode without memory strap");
  irq_any_a: assert property (irq_o == (int_vector_req_o != 4'h0))
    else $error("irq disagrees with vector requests");
  serial_sel_a: assert property (reg_write_i && reg_addr_i == ADDR_SYS_CTRL |->
    ##2 serial_shared_sel_o == $past(reg_wdata_i[SCTRL_SERIAL_SEL_BIT], 2))
    else $error("serial select did not follow write");
  flag_out_a: assert property (reg_write_i && reg_addr_i == ADDR_FLAG_OUT |->
    ##2 flag_pin_o == $past(reg_wdata_i[7:0], 2))
    else $error("flag out did not follow write");
  flag_dir_a: assert property (reg_write_i && reg_addr_i == ADDR_FLAG_DIR |->
    ##2 flag_pin_oe_o == $past(reg_wdata_i[7:0], 2))
    else $error("flag enable did not follow write");
  irq_clear_a: assert property ($fell(irq_o) |-> $past(reg_write_i) || $past(reg_write_i, 2))
    else $error("irq dropped without a write");
  reset_quiet_a: assert property ($rose(reset_n_i) |->
    (strap_value_o == 4'h0 && flag_pin_oe_o == 8'h00) [*3])
    else $error("outputs active before strap capture");
endmodule // dfpm_pin_mux_properties

bind dfpm_pin_mux dfpm_pin_mux_properties dfpm_pin_mux_properties_inst (.*);

// *** verif/dfpm_pin_partner.sv ***
// Board-side model of the devices on the shared flag, strap and interrupt pins.
`timescale 1ns/1ns
module dfpm_pin_partner
  import dfpm_pkg::*;
(
  input wire logic [FLAG_COUNT-1:0] drive_i,
  input wire logic [FLAG_COUNT-1:0] oe_i,
  input wire logic [FLAG_COUNT-1:0] ext_val_i,
  input wire logic [FLAG_COUNT-1:0] ext_en_i,
  output logic [FLAG_COUNT-1:0] pin_o
);
  // Each pin has a pull-up, so a released interrupt line reads as not asserted.
  assign pin_o = (oe_i & drive_i) | (~oe_i & ext_en_i & ext_val_i) | (~oe_i & ~ext_en_i);
endmodule // dfpm_pin_partner

// *** verif/test_dual_function_pin_mux.sv ***
// Self-checking bench for the dual function pin mux.
`timescale 1ns/1ns
module test_dual_function_pin_mux
  import dfpm_pkg::*;
;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_write_i = 1'b0;
  logic reg_read_i = 1'b0;
  logic [15:0] reg_rdata_o;
  logic [7:0] flag_pin_i, flag_pin_o, flag_pin_oe_o;
  logic serial_shared_sel_o, host_mode_o, irq_o;
  logic [3:0] strap_value_o, int_vector_req_o;
  logic [7:0] ext_val = 8'hff;
  logic [7:0] ext_en = 8'h00;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  always #2 core_clk_i = ~core_clk_i;
  dfpm_pin_mux dfpm_pin_mux_inst (.*);
  dfpm_pin_partner dfpm_pin_partner_inst (.drive_i(flag_pin_o), .oe_i(flag_pin_oe_o),
    .ext_val_i(ext_val), .ext_en_i(ext_en), .pin_o(flag_pin_i));
  task check16(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task ck(input logic [15:0] exp);
    check16({11'h000, irq_o, int_vector_req_o}, exp);
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge core_clk_i);
    reg_write_i <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge core_clk_i);
    reg_read_i <= 1'b0;
    #1 check16(reg_rdata_o, exp);
    @(posedge core_clk_i);
  endtask
  task st;
    repeat (3) @(posedge core_clk_i);
    #1;
  endtask
  // Straps are held a few edges past release so the late capture still sees them.
  task do_reset(input logic [3:0] s);
    reset_n_i <= 1'b0;
    ext_en <= 8'h0f;
    ext_val <= {4'hf, s};
    repeat (20) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    ext_en <= 8'h00;
    st;
  endtask
  task finish_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge core_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      errors = errors + 1;
      finish_test;
    end
  end
  initial
  begin
    do_reset(4'h5);
    check16({11'h000, host_mode_o, strap_value_o}, 16'h0015);
    wr(ADDR_FLAG_DIR, 16'h000f);
    wr(ADDR_FLAG_OUT, 16'h0003);
    st;
    check16({flag_pin_oe_o, flag_pin_o}, 16'h0f03);
    rd(ADDR_FLAG_IN, 16'h00f3);
    wr(ADDR_STRAPS, 16'h000a);
    rd(ADDR_STRAPS, 16'h0005);
    wr(ADDR_SYS_CTRL, 16'h0001);
    st;
    check16({15'h0000, serial_shared_sel_o}, 16'h0001);
    wr(ADDR_INT_MASK, 16'h000f);
    for (int b = 0; b < 5; b++)
    begin
      if (b == 4)
        wr(ADDR_SENSE_CFG, 16'h0001);
      ext_val[7 - b % 4] <= 1'b0;
      ext_en[7 - b % 4] <= 1'b1;
      st;
      ck({12'h001, 4'h1 << (b % 4)});
      wr(ADDR_INT_STATUS, 16'h0001 << (b % 4));
      st;
      rd(ADDR_INT_STATUS, (b < 3) ? 16'h0001 << b : 16'h0000);
      ext_en <= 8'h00;
      st;
      wr(ADDR_INT_STATUS, 16'h000f);
      rd(ADDR_INT_STATUS, 16'h0000);
    end
    wr(ADDR_INT_MASK, 16'h0000);
    ext_en[5] <= 1'b1;
    st;
    ck(16'h0000);
    rd(ADDR_INT_STATUS, 16'h0004);
    ext_en <= 8'h00;
    wr(ADDR_INT_MASK, 16'h000f);
    st;
    ck(16'h0014);
    wr(ADDR_INT_STATUS, 16'h000f);
    wr(ADDR_FLAG_DIR, 16'h004f);
    st;
    ck(16'h0012);
    rd(ADDR_FLAG_IN, 16'h00b3);
    wr(ADDR_FLAG_DIR, 16'h000f);
    st;
    wr(ADDR_INT_STATUS, 16'h000f);
    wr(ADDR_SYS_CTRL, 16'h0000);
    st;
    check16({15'h0000, serial_shared_sel_o}, 16'h0000);
    rd(ADDR_SYS_CTRL, 16'h0000);
    rd(4'hf, 16'h0000);
    do_reset(4'h0);
    check16({11'h000, host_mode_o, strap_value_o}, 16'h0000);
    finish_test;
  end
endmodule // test_dual_function_pin_mux
